// ===== design/e1_alarm_status.sv
// receive alarm and status word logic with host read port
`include "e1_alarm_regs.svh"
module e1_alarm_status (
	// clock and reset
	input  wire logic                       clock,
	input  wire logic                       reset_n,
	// framer timing and line events, same clock domain
	input  wire e1_alarm_pkg::line_events_t ev,
	// control
	input  wire logic                       all_ones_criterion_select,
	// host port
	input  wire e1_alarm_pkg::host_req_t    host,
	output logic [7:0]                      rd_data
);
	typedef struct packed {
		logic       submf_one_check_fail;
		logic       submf_two_check_fail;
		logic       remote_generator_failure;
		logic       los;
		logic       ts16_all_ones_alarm;
		logic       all_ones_alarm;
		logic       remote_alarm_status;
		logic       remote_alarm_crc_combined;
		logic [6:0] zero_run;
		logic [6:0] win_cnt;
		logic [6:0] win_ones;
		logic       win_active;
		logic [9:0] ebit_cnt;
		logic       sec_bad;
		logic [2:0] bad_secs;
		logic [1:0] ais_zero_cnt;
		logic       frame_ok;
		logic [3:0] last_nibble;
		logic       have_nibble;
		logic [2:0] same_cnt;
		logic       sa5_latch;
		logic [3:0] nibble_latch;
		logic       stable_nibble_eight;
		logic       nibble_changed;
		logic [7:0] rd_data;
	} state_t;
	state_t s_reg, s_next;
	logic [7:0] status_word, report_word;
	always_comb begin
		status_word = {s_reg.submf_one_check_fail, s_reg.submf_two_check_fail,
			s_reg.remote_generator_failure, s_reg.los, s_reg.ts16_all_ones_alarm,
			s_reg.all_ones_alarm, s_reg.remote_alarm_status, s_reg.remote_alarm_crc_combined};
		report_word = {s_reg.sa5_latch, s_reg.nibble_latch, 1'b0,
			s_reg.stable_nibble_eight, s_reg.nibble_changed};
	end
	always_comb begin
		s_next = s_reg;
		// ==============================
		// crc submultiframes
		if (ev.sm1_end)
			s_next.submf_one_check_fail = ev.crc_fail;
		if (ev.sm2_end)
			s_next.submf_two_check_fail = ev.crc_fail;
		// ==============================
		// remote generator failure
		if (ev.e_error && s_reg.ebit_cnt != 10'h3ff)
			s_next.ebit_cnt = s_reg.ebit_cnt + 10'h001;
		// a bit only means rai when its nfas strobe is up
		if ((ev.nfas_frame && ev.a_bit) || ev.sync_lost)
			s_next.sec_bad = 1'b1;
		if (ev.sec_tick) begin
			s_next.ebit_cnt = 10'h000;
			s_next.sec_bad = 1'b0;
			// a second counts only with >989 errors, no rai, no lost alignment
			if (s_reg.ebit_cnt > `EBIT_LIMIT && !s_reg.sec_bad && !(ev.nfas_frame && ev.a_bit)
					&& !ev.sync_lost)
				s_next.bad_secs = (s_reg.bad_secs == `BAD_SECONDS) ? s_reg.bad_secs
					: s_reg.bad_secs + 3'h1;
			else
				s_next.bad_secs = 3'h0;
			s_next.remote_generator_failure = (s_next.bad_secs == `BAD_SECONDS);
		end
		// ==============================
		// loss of signal
		if (ev.bit_en) begin
			s_next.zero_run = ev.line_bit ? 7'h00
				: (s_reg.zero_run == `LOS_WINDOW ? s_reg.zero_run : s_reg.zero_run + 7'h01);
			if (!s_reg.los && !ev.line_bit && s_reg.zero_run == `LOS_WINDOW - 7'h01)
				s_next.los = 1'b1;
			if (s_reg.los) begin
				if (!s_reg.win_active) begin
					// window opens only on a pulse
					s_next.win_active = ev.line_bit;
					s_next.win_cnt = 7'h01;
					s_next.win_ones = 7'h01;
				end else begin
					s_next.win_cnt = s_reg.win_cnt + 7'h01;
					s_next.win_ones = s_reg.win_ones + {6'h00, ev.line_bit};
					if (s_reg.win_cnt == `LOS_WINDOW - 7'h01) begin
						s_next.win_active = 1'b0;
						if (s_next.win_ones >= `LOS_MIN_ONES)
							s_next.los = 1'b0;
					end
				end
			end else
				s_next.win_active = 1'b0;
			// ==============================
			// all ones detection: zeros per frame, threshold by select
			// saturates at three, all that the wider criterion needs
			if (!ev.line_bit && s_reg.ais_zero_cnt != 2'h3)
				s_next.ais_zero_cnt = s_reg.ais_zero_cnt + 2'h1;
		end
		if (ev.frame_start) begin
			s_next.all_ones_alarm = all_ones_criterion_select
				? (s_reg.ais_zero_cnt < `AIS_ZEROS_B)
				: (s_reg.ais_zero_cnt < `AIS_ZEROS_A);
			s_next.ais_zero_cnt = 2'h0;
		end
		if (ev.ts16_end)
			s_next.ts16_all_ones_alarm = ev.ts16_ones;
		if (ev.nfas_frame)
			s_next.remote_alarm_status = ev.a_bit;
		if (ev.mf_start)
			s_next.remote_alarm_crc_combined = ev.a_bit & ev.crc_continuous;
		// ==============================
		// sa6 nibble monitor, host read clear
		if (host.rd && host.addr == `ADDR_NIBBLE_REPORT) begin
			s_next.sa5_latch = 1'b0;
			s_next.nibble_latch = 4'h0;
			s_next.stable_nibble_eight = 1'b0;
			s_next.nibble_changed = 1'b0;
		end
		// set wins over a clearing read in the same cycle
		if (ev.sa_nibble_valid) begin
			s_next.have_nibble = 1'b1;
			s_next.last_nibble = ev.sa6_nibble;
			if (s_reg.have_nibble && ev.sa6_nibble != s_reg.last_nibble) begin
				s_next.nibble_changed = 1'b1;
				s_next.same_cnt = 3'h0;
			end else if (s_reg.have_nibble && s_reg.same_cnt != `STABLE_COUNT) begin
				s_next.same_cnt = s_reg.same_cnt + 3'h1;
				if (s_reg.same_cnt == `STABLE_COUNT - 3'h1) begin
					s_next.stable_nibble_eight = 1'b1;
					s_next.sa5_latch = ev.sa5_bit;
					s_next.nibble_latch = ev.sa6_nibble;
				end
			end
		end
		// ==============================
		// read data, alarm status read is side-effect free
		unique case (host.addr)
			`ADDR_ALARM_STATUS_ONE: s_next.rd_data = status_word;
			`ADDR_NIBBLE_REPORT:    s_next.rd_data = report_word;
			`ADDR_DEVICE_ID:        s_next.rd_data = `DEVICE_CODE;
			default:                s_next.rd_data = 8'h00;
		endcase
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end
	assign rd_data = s_reg.rd_data;
	// ==============================
	// checks
	chk_sm1_update: assert property (@(posedge clock) disable iff (!reset_n)
		ev.sm1_end |=> s_reg.submf_one_check_fail == $past(ev.crc_fail))
		else $error("sm1 status not refreshed");
	chk_sm2_update: assert property (@(posedge clock) disable iff (!reset_n)
		ev.sm2_end |=> s_reg.submf_two_check_fail == $past(ev.crc_fail))
		else $error("sm2 status not refreshed");
	chk_remote_fail_hold: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(s_reg.remote_generator_failure) |-> s_reg.bad_secs == `BAD_SECONDS)
		else $error("remote failure without five bad seconds");
	chk_los_enter: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(s_reg.los) |-> s_reg.zero_run == `LOS_WINDOW)
		else $error("los entered early");
	chk_los_exit: assert property (@(posedge clock) disable iff (!reset_n)
		$fell(s_reg.los) |-> $past(s_reg.win_cnt) == `LOS_WINDOW - 7'h01)
		else $error("los left without full window");
	chk_ts16_frame: assert property (@(posedge clock) disable iff (!reset_n)
		ev.ts16_end |=> s_reg.ts16_all_ones_alarm == $past(ev.ts16_ones))
		else $error("ts16 alarm not updated");
	chk_ais_frame: assert property (@(posedge clock) disable iff (!reset_n)
		!ev.frame_start |=> $stable(s_reg.all_ones_alarm))
		else $error("all ones alarm changed outside frame start");
	chk_rai_nfas: assert property (@(posedge clock) disable iff (!reset_n)
		!ev.nfas_frame |=> $stable(s_reg.remote_alarm_status))
		else $error("rai changed outside nfas");
	chk_rai_crc_mf: assert property (@(posedge clock) disable iff (!reset_n)
		ev.mf_start |=> s_reg.remote_alarm_crc_combined
			== $past(ev.a_bit & ev.crc_continuous))
		else $error("rai crc bit wrong");
	chk_stable_latch: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(s_reg.stable_nibble_eight) |-> s_reg.same_cnt == `STABLE_COUNT)
		else $error("stable flag without eight equal nibbles");
	chk_change_set: assert property (@(posedge clock) disable iff (!reset_n)
		ev.sa_nibble_valid && s_reg.have_nibble && ev.sa6_nibble != s_reg.last_nibble
		|=> s_reg.nibble_changed)
		else $error("nibble change lost");
	chk_status_read: assert property (@(posedge clock) disable iff (!reset_n)
		host.rd && host.addr == `ADDR_ALARM_STATUS_ONE
		|=> s_reg.rd_data == $past(status_word))
		else $error("status read wrong");
endmodule

// ===== design/e1_alarm_regs.svh
// register offsets, field positions and timing constants for the receive alarm block
// What this block does
// - sm1 crc fail bit, refreshed each sm1
// - sm2 crc fail bit, refreshed each sm2
// - remote failure: five bad seconds, no rai, aligned
// - 127 zero bits enter loss of signal
// - 127 positions, pulse first, 12.5% ones exit
// - ts16 all ones alarm, evaluated each frame
// - all ones alarm, criterion chosen by select
// - remote alarm follows a bit each nfas
// - rai plus crc errors, updated per multiframe
// - eighth equal nibble latches flag, sa5, nibble
// - nibble change sets flag, read clears
`ifndef E1_ALARM_REGS_SVH
`define E1_ALARM_REGS_SVH
`define ADDR_ALARM_STATUS_ONE  5'h19
`define ADDR_NIBBLE_REPORT     5'h1a
`define ADDR_DEVICE_ID         5'h1f
`define BIT_SM1_FAIL           7
`define BIT_SM2_FAIL           6
`define BIT_REMOTE_FAIL        5
`define BIT_LOS                4
`define BIT_TS16_AIS           3
`define BIT_AIS                2
`define BIT_RAI                1
`define BIT_RAI_CRC            0
`define BIT_SA5                7
`define BIT_STABLE             1
`define BIT_CHANGED            0
// arbitrary identification value, chosen to match no real maker code
`define DEVICE_CODE            8'h5c
`define LOS_WINDOW             7'h7f
`define LOS_MIN_ONES           7'h10
`define EBIT_LIMIT             10'h3dd
`define BAD_SECONDS            3'h5
`define STABLE_COUNT           3'h7
`define AIS_ZEROS_A            2'h2
`define AIS_ZEROS_B            2'h3
`endif

// ===== design/e1_alarm_pkg.sv
// types shared by the receive alarm block
package e1_alarm_pkg;
	typedef struct packed {
		logic       bit_en;
		logic       line_bit;
		logic       frame_start;
		logic       nfas_frame;
		logic       mf_start;
		logic       sm1_end;
		logic       sm2_end;
		logic       crc_fail;
		logic       ts16_end;
		logic       ts16_ones;
		logic       a_bit;
		logic       e_error;
		logic       sec_tick;
		logic       sync_lost;
		logic       crc_continuous;
		logic       sa_nibble_valid;
		logic [3:0] sa6_nibble;
		logic       sa5_bit;
	} line_events_t;
	typedef struct packed {
		logic [4:0] addr;
		logic       rd;
	} host_req_t;
endpackage

// ===== testbench/e1_line_source.sv
// partner model: remote line terminal feeding framed line events
module e1_line_source (
	// clock
	input  wire logic                 clock,
	// events toward the block
	output e1_alarm_pkg::line_events_t ev
);
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================
	// event strobes
	initial ev = '0;
	// one strobe per call, levels ride with it; gap lets the far end run slow
	task automatic send(input int kind, input logic lvl, input logic [3:0] nib, input int gap);
		e1_alarm_pkg::line_events_t e;
		e = '0;
		e.sm1_end = (kind == 0);
		e.sm2_end = (kind == 1);
		e.ts16_end = (kind == 2);
		e.nfas_frame = (kind == 3);
		e.mf_start = (kind == 4);
		e.bit_en = (kind == 5);
		e.sa_nibble_valid = (kind == 6);
		e.e_error = (kind == 7);
		e.sec_tick = (kind == 8);
		e.frame_start = (kind == 9);
		e.crc_fail = lvl;
		e.ts16_ones = lvl;
		e.a_bit = lvl;
		e.crc_continuous = lvl;
		e.line_bit = lvl;
		e.sa5_bit = lvl;
		e.sa6_nibble = nib;
		@(posedge clock);
		ev <= e;
		@(posedge clock);
		ev <= '0;
		repeat (gap) @(posedge clock);
	endtask
endmodule

// ===== testbench/tb.sv
// self-checking bench for the receive alarm status block
`include "e1_alarm_regs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                       clock;
	logic                       reset_n;
	logic                       sel;
	e1_alarm_pkg::line_events_t ev;
	e1_alarm_pkg::host_req_t    host;
	logic [7:0]                 rd_data;
	logic [7:0]                 q[$];
	logic                       rd_seen = 1'b0;
	logic [3:0]                 nib;
	int                         seed;
	int                         miscompares = 0;
	int                         check_count = 0;
	e1_alarm_status e1_alarm_status_i (.clock(clock), .reset_n(reset_n), .ev(ev),
		.all_ones_criterion_select(sel), .host(host), .rd_data(rd_data));
	e1_line_source e1_line_source_i (.clock(clock), .ev(ev));
	// =====================================
	// clock, compare, verdict
	always #4 clock = ~clock;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		if (miscompares == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// read data lands one cycle after the address edge
	always @(posedge clock) begin
		if (rd_seen) check(rd_data, q.pop_front());
		rd_seen <= host.rd;
	end
	task automatic read(input logic [4:0] a, input logic [7:0] exp);
		@(posedge clock);
		host <= '{addr: a, rd: 1'b1};
		q.push_back(exp);
		@(posedge clock);
		host.rd <= 1'b0;
	endtask
	initial begin
		repeat (30000) @(posedge clock);
		miscompares++;
		report_and_stop();
	end
	// =====================================
	// scenarios
	initial begin
		clock = 1'b0;
		reset_n = 1'b0;
		sel = 1'b0;
		host = '0;
		seed = 50245;
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		sel <= 1'($random(seed));
		read(`ADDR_ALARM_STATUS_ONE, 8'h00);
		read(`ADDR_NIBBLE_REPORT, 8'h00);
		read(`ADDR_DEVICE_ID, `DEVICE_CODE);
		read(5'h05, 8'h00);
		e1_line_source_i.send(0, 1'b1, 4'h0, 0);
		read(`ADDR_ALARM_STATUS_ONE, 8'h80);
		e1_line_source_i.send(0, 1'b0, 4'h0, 0);
		e1_line_source_i.send(1, 1'b1, 4'h0, 2);
		read(`ADDR_ALARM_STATUS_ONE, 8'h40);
		e1_line_source_i.send(2, 1'b1, 4'h0, 0);
		read(`ADDR_ALARM_STATUS_ONE, 8'h48);
		e1_line_source_i.send(3, 1'b1, 4'h0, 3);
		read(`ADDR_ALARM_STATUS_ONE, 8'h4a);
		e1_line_source_i.send(4, 1'b1, 4'h0, 0);
		read(`ADDR_ALARM_STATUS_ONE, 8'h4b);
		// zero run just long enough to enter loss of signal
		repeat (127) e1_line_source_i.send(5, 1'b0, 4'h0, 0);
		read(`ADDR_ALARM_STATUS_ONE, 8'h5b);
		// exactly one pulse in eight, the minimum density that clears it
		for (int i = 0; i < 127; i++) e1_line_source_i.send(5, (i % 8) == 0, 4'h0, 0);
		read(`ADDR_ALARM_STATUS_ONE, 8'h4b);
		read(`ADDR_ALARM_STATUS_ONE, 8'h4b);
		// the rai seen earlier spoils the open second, so close it first
		e1_line_source_i.send(8, 1'b0, 4'h0, 0);
		for (int s = 0; s < 5; s++) begin
			repeat (990) e1_line_source_i.send(7, 1'b0, 4'h0, 0);
			e1_line_source_i.send(8, 1'b0, 4'h0, 0);
			read(`ADDR_ALARM_STATUS_ONE, (s == 4) ? 8'h6b : 8'h4b);
		end
		// 989 errors is not above the limit, so the run of bad seconds ends
		repeat (989) e1_line_source_i.send(7, 1'b0, 4'h0, 0);
		e1_line_source_i.send(8, 1'b0, 4'h0, 0);
		read(`ADDR_ALARM_STATUS_ONE, 8'h4b);
		// first frame start closes a window full of zeros, second a clean one
		e1_line_source_i.send(9, 1'b0, 4'h0, 0);
		repeat (3) e1_line_source_i.send(5, 1'b1, 4'h0, 0);
		e1_line_source_i.send(9, 1'b0, 4'h0, 0);
		read(`ADDR_ALARM_STATUS_ONE, 8'h4f);
		// two zeros pass only the wider criterion
		repeat (2) e1_line_source_i.send(5, 1'b0, 4'h0, 0);
		e1_line_source_i.send(9, 1'b0, 4'h0, 0);
		read(`ADDR_ALARM_STATUS_ONE, {5'h09, sel, 2'h3});
		repeat (8) e1_line_source_i.send(6, 1'b1, 4'h0, 0);
		read(`ADDR_NIBBLE_REPORT, 8'h82);
		read(`ADDR_NIBBLE_REPORT, 8'h00);
		nib = 4'($random(seed)) | 4'h1;
		e1_line_source_i.send(6, 1'b0, nib, 0);
		read(`ADDR_NIBBLE_REPORT, 8'h01);
		read(`ADDR_NIBBLE_REPORT, 8'h00);
		repeat (7) e1_line_source_i.send(6, 1'b1, nib, 0);
		read(`ADDR_NIBBLE_REPORT, {1'b1, nib, 3'b010});
		repeat (4) @(posedge clock);
		report_and_stop();
	end
endmodule
